// File: include/clkgen_pkg.sv
package clkgen_pkg;

    // ************************************************************
    // Field widths and limits
    // ************************************************************
    localparam int           MUL_W      = 5;
    localparam int           NCO_W      = 12;
    localparam int           ERR_W      = 12;
    localparam int           DIV_W      = 6;
    localparam logic [3:0]   ODIV_MAX   = 4'hE;
    localparam logic [5:0]   DIV_MAX    = 6'h3C;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0]       SRC_PLL    = 2'h3;
    localparam logic [1:0]       BAND_RSVD  = 2'h3;
    localparam logic [1:0]       BAND_RST   = 2'h0;
    localparam logic [NCO_W-1:0] INC_RST    = 12'h100;
    localparam logic [NCO_W-1:0] INC_MIN    = 12'h001;
    localparam logic [NCO_W-1:0] INC_MAX    = 12'hFFF;

    typedef enum logic {
        MODE_BYPASS,
        MODE_PLL
    } mode_t;

    typedef struct packed {
        logic [1:0]       clock_source_select;
        logic [1:0]       input_prescale_field;
        logic [3:0]       output_prescale_field;
        logic [MUL_W-1:0] feedback_multiply_field;
        logic [1:0]       vco_band_select;
    } clock_gen_config_t;

endpackage : clkgen_pkg

// File: verilog/vco_nco.sv
`timescale 1ns/100ps
`default_nettype none

module vco_nco
    import clkgen_pkg::*;
#(
    parameter int W = NCO_W
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_inc,
    output var  logic         o_tick
);

    generate
        if (W < 2) begin : g_bad_w
            $error("W must be at least 2");
        end
    endgenerate

    // Each carry out of the phase accumulator marks one VCO half period.
    logic [W-1:0] acc_r;
    logic [W:0]   sum;

    assign sum = {1'b0, acc_r} + {1'b0, i_inc};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc_r  <= '0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            acc_r  <= sum[W-1:0];
            o_tick <= sum[W];
        end
    end

endmodule : vco_nco

`default_nettype wire

// File: verilog/master_clock_generator.sv
// Summary of operation
// - Source code with upper bit clear selects bypass through both prescalers.
// - Bypass divides oscillator by (input prescale+1) times (output prescale+1).
// - Both prescales zero: master clock follows oscillator, keeping its duty cycle.
// - Input prescale reaches 3, output prescale 14, slowest division 60.
// - Source code 11 enables the loop and takes master from it.
// - Loop mode: oscillator times (multiply+1) over both prescale factors.
// - Loop frequency is pulled toward lock gradually, but the error-sign trim steps the NCO increment by 8 at once.
// - Loop VCO output is divided by output prescale plus one.
// - CPU clock is master clock or half of it, chosen by one bit.
// - System clock for peripherals runs at the CPU clock frequency.
// - Band code picks the VCO range; code 11 is reserved.
`timescale 1ns/100ps
`default_nettype none

module master_clock_generator
    import clkgen_pkg::*;
#(
    parameter int ERR_BITS = ERR_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_crystal_input_pin,
    input  wire clock_gen_config_t i_clock_gen_config,
    input  wire logic              i_cpu_halving_select,
    output var  logic              o_master_clk,
    output var  logic              o_cpu_clk,
    output var  logic              o_sys_clk,
    output var  logic              o_pll_active,
    output var  logic [1:0]        o_vco_band,
    output var  logic              o_band_error
);

    generate
        if (ERR_BITS < 9 || ERR_BITS > 24) begin : g_bad_err
            $error("ERR_BITS must lie between 9 and 24");
        end
    endgenerate

    // ************************************************************
    // Oscillator pin synchroniser and edge detection
    // ************************************************************
    logic osc_s1_r, osc_s2_r, osc_s3_r;
    logic osc_edge, osc_rise;

    assign osc_edge = osc_s2_r ^ osc_s3_r;
    assign osc_rise = osc_s2_r & ~osc_s3_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else if (i_ce) begin
            osc_s1_r <= i_crystal_input_pin;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // ************************************************************
    // Active configuration, taken over only at a safe point
    // ************************************************************
    mode_t            mode_r;
    logic [1:0]       idiv_r;
    logic [3:0]       odiv_r;
    logic [MUL_W-1:0] mul_r;
    logic             half_r;
    logic [DIV_W-1:0] cnt_r;
    logic             apply_ok;
    logic             src_bypass, src_pll;
    logic [3:0]       odiv_lim;

    // The switch point is after a falling master edge with both clocks low.
    assign apply_ok   = ~o_master_clk & ~o_cpu_clk & (cnt_r == '0);
    assign src_bypass = ~i_clock_gen_config.clock_source_select[1];
    assign src_pll    = i_clock_gen_config.clock_source_select == SRC_PLL;
    assign odiv_lim   = (i_clock_gen_config.output_prescale_field > ODIV_MAX) ?
                        ODIV_MAX : i_clock_gen_config.output_prescale_field;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_r <= MODE_BYPASS;
            idiv_r <= '0;
            odiv_r <= '0;
            mul_r  <= '0;
            half_r <= 1'b0;
        end else if (i_ce && apply_ok) begin
            if (src_bypass) begin
                mode_r <= MODE_BYPASS;
            end else if (src_pll) begin
                mode_r <= MODE_PLL;
            end
            idiv_r <= i_clock_gen_config.input_prescale_field;
            odiv_r <= odiv_lim;
            mul_r  <= i_clock_gen_config.feedback_multiply_field;
            half_r <= i_cpu_halving_select;
        end
    end

    // ************************************************************
    // Digital loop: phase error steers the NCO increment
    // ************************************************************
    logic [NCO_W-1:0]      inc_r;
    logic signed [ERR_BITS-1:0] err_r;
    logic signed [ERR_BITS:0]   err_wide;
    logic signed [ERR_BITS-1:0] err_nxt;
    logic                  vco_tick;
    logic [7:0]            e_add, e_sub;
    logic                  err_ovf;
    logic                  in_pll;

    assign in_pll   = mode_r == MODE_PLL;
    assign e_add    = vco_tick ? {6'h0, idiv_r} + 8'h01 : 8'h00;
    assign e_sub    = osc_rise ? {2'h0, mul_r, 1'b0} + 8'h02 : 8'h00;
    assign err_wide = $signed({err_r[ERR_BITS-1], err_r} + (ERR_BITS+1)'(e_add)
                      - (ERR_BITS+1)'(e_sub));
    assign err_ovf  = err_wide[ERR_BITS] ^ err_wide[ERR_BITS-1];
    assign err_nxt  = !err_ovf ? err_wide[ERR_BITS-1:0] :
                      err_wide[ERR_BITS] ? {1'b1, {(ERR_BITS-1){1'b0}}} :
                                           {1'b0, {(ERR_BITS-1){1'b1}}};

    // A small proportional trim on the NCO damps the loop.
    // The integrating path alone would swing around lock without ever settling.
    localparam logic [NCO_W-1:0] TRIM = 12'h008;
    logic [NCO_W-1:0]      nco_inc;
    logic                  err_pos, err_neg;

    assign err_neg = err_r[ERR_BITS-1];
    assign err_pos = !err_r[ERR_BITS-1] && err_r != '0;
    assign nco_inc = (err_neg && inc_r <= INC_MAX - TRIM) ? inc_r + TRIM :
                     (err_pos && inc_r > TRIM) ? inc_r - TRIM : inc_r;

    vco_nco #(
        .W      (NCO_W)
    ) u_nco (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce & in_pll),
        .i_inc  (nco_inc),
        .o_tick (vco_tick)
    );

    // The increment moves by one step per oscillator period at most.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            inc_r <= INC_RST;
            err_r <= '0;
        end else if (i_ce) begin
            err_r <= in_pll ? err_nxt : '0;
            if (in_pll && osc_rise) begin
                if (!err_nxt[ERR_BITS-1] && err_nxt != '0 && inc_r != INC_MIN) begin
                    inc_r <= inc_r - 12'h001;
                end else if (err_nxt[ERR_BITS-1] && inc_r != INC_MAX) begin
                    inc_r <= inc_r + 12'h001;
                end
            end
        end
    end

    // ************************************************************
    // Output divider and CPU and system clocks
    // ************************************************************
    logic [DIV_W-1:0] k_div;
    logic             evt, wrap, master_nxt, cpu_nxt;

    assign k_div      = in_pll ? {2'h0, odiv_r} + 6'h01 :
                        ({4'h0, idiv_r} + 6'h01) * ({2'h0, odiv_r} + 6'h01);
    assign evt        = in_pll ? vco_tick : osc_edge;
    assign wrap       = evt && (cnt_r == k_div - 6'h01);
    assign master_nxt = wrap ? ~o_master_clk : o_master_clk;
    assign cpu_nxt    = !half_r ? master_nxt :
                        (master_nxt & ~o_master_clk) ? ~o_cpu_clk : o_cpu_clk;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r        <= '0;
            o_master_clk <= 1'b0;
            o_cpu_clk    <= 1'b0;
            o_sys_clk    <= 1'b0;
        end else if (i_ce) begin
            cnt_r        <= wrap ? '0 : evt ? cnt_r + 6'h01 : cnt_r;
            o_master_clk <= master_nxt;
            o_cpu_clk    <= cpu_nxt;
            o_sys_clk    <= cpu_nxt;
        end
    end

    // ************************************************************
    // Band selection and status
    // ************************************************************
    logic band_bad;

    assign band_bad = i_clock_gen_config.vco_band_select == BAND_RSVD;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_vco_band   <= BAND_RST;
            o_band_error <= 1'b0;
            o_pll_active <= 1'b0;
        end else if (i_ce) begin
            o_band_error <= band_bad;
            o_pll_active <= in_pll;
            if (!band_bad) begin
                o_vco_band <= i_clock_gen_config.vco_band_select;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    mode_bypass_a: assert property (i_ce && apply_ok && src_bypass |=> mode_r == MODE_BYPASS)
        else $error("bypass source not taken");
    bypass_div_a: assert property (i_ce && !in_pll && osc_edge && cnt_r != k_div - 6'h01
        |=> $stable(o_master_clk))
        else $error("bypass divider toggled early");
    follow_osc_a: assert property (i_ce && !in_pll && k_div == 6'h01 && osc_edge
        |=> $changed(o_master_clk))
        else $error("master did not follow oscillator");
    div_range_a: assert property (k_div <= DIV_MAX && k_div != '0)
        else $error("division factor out of range");
    mode_pll_a: assert property (i_ce && apply_ok && src_pll
        |=> ##1 (o_pll_active || !$past(i_ce)))
        else $error("loop source not taken");
    pll_div_a: assert property (i_ce && in_pll && vco_tick && cnt_r == {2'h0, odiv_r}
        |=> $changed(o_master_clk))
        else $error("loop divider missed its toggle");
    slew_step_a: assert property (##1 (inc_r == $past(inc_r) || inc_r == $past(inc_r) + 12'h001
        || inc_r == $past(inc_r) - 12'h001))
        else $error("increment stepped abruptly");
    cpu_half_a: assert property ($changed(o_cpu_clk) && $past(half_r) |-> $rose(o_master_clk))
        else $error("halved cpu clock moved off a master rise");
    sys_eq_a: assert property (o_sys_clk == o_cpu_clk)
        else $error("system clock differs from cpu clock");
    band_rsvd_a: assert property (i_ce && band_bad |=> o_band_error && $stable(o_vco_band))
        else $error("reserved band accepted");
    switch_low_a: assert property ($changed(mode_r) || $changed(half_r)
        |-> !$past(o_master_clk) && !$past(o_cpu_clk))
        else $error("clock switched while high");

    pll_entry_c: cover property (i_ce && apply_ok && src_pll ##1 o_pll_active);
    half_on_c: cover property ($rose(half_r));
    band_err_c: cover property ($rose(o_band_error));
    slow_div_c: cover property (k_div == DIV_MAX && wrap);

endmodule : master_clock_generator

`default_nettype wire

// File: tb/osc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Free-running oscillator with programmable high and low times
// ************************************************************
module osc_model (
    input  wire logic [15:0] i_high_ns,
    input  wire logic [15:0] i_low_ns,
    output var  logic        o_osc
);
    // Edges sit 7 ns before a rising system clock edge, so sampling never races.
    initial begin
        o_osc = 1'b0;
        #13;
        forever begin
            o_osc = 1'b1;
            #(i_high_ns);
            o_osc = 1'b0;
            #(i_low_ns);
        end
    end
endmodule : osc_model

`default_nettype wire

// File: tb/tb_master_clock_generator.sv
`timescale 1ns/100ps
`default_nettype none

module tb_master_clock_generator;
    import clkgen_pkg::*;

    // ************************************************************
    // Stimulus, design and oscillator
    // ************************************************************
    logic              i_clk = 1'b0;
    logic              i_rst = 1'b1;
    logic              i_ce  = 1'b1;
    logic              half  = 1'b0;
    clock_gen_config_t cfg   = '0;
    logic [15:0]       hi_ns = 16'h00C8;
    logic [15:0]       lo_ns = 16'h0078;
    logic              osc, mclk, cclk, sclk, pll, berr;
    logic [1:0]        band;
    int                failures = 0, comparisons = 0, cycles = 0;
    int                p, h, q;

    always #20 i_clk = ~i_clk;

    osc_model u_osc_model (.i_high_ns(hi_ns), .i_low_ns(lo_ns), .o_osc(osc));

    master_clock_generator u_master_clock_generator (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_crystal_input_pin(osc),
        .i_clock_gen_config(cfg), .i_cpu_halving_select(half),
        .o_master_clk(mclk), .o_cpu_clk(cclk), .o_sys_clk(sclk),
        .o_pll_active(pll), .o_vco_band(band), .o_band_error(berr));

    task automatic print_verdict;
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check

    task automatic set_cfg(logic [1:0] s, logic [1:0] id, logic [3:0] od,
                           logic [4:0] m, logic [1:0] b, logic hv, int settle);
        @(posedge i_clk);
        cfg  <= '{s, id, od, m, b};
        half <= hv;
        repeat (settle) @(posedge i_clk);
        @(negedge i_clk);
    endtask : set_cfg

    // Counts cycles and high cycles over n whole periods, rise to rise.
    task automatic measure(int sel, int n, output int per, output int hi);
        logic prev, cur;
        int   k;
        per = 0;
        hi = 0;
        k = 0;
        prev = 1'b1;
        while (k <= n) begin
            @(negedge i_clk);
            cur = (sel == 0) ? mclk : cclk;
            if (cur === 1'b1 && prev === 1'b0) k++;
            if (k > 0 && k <= n) begin
                per++;
                if (cur === 1'b1) hi++;
            end
            prev = cur;
        end
    endtask : measure

    task automatic t_bypass;
        logic [1:0] id [5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2};
        logic [3:0] od [5] = '{4'h0, 4'h1, 4'hE, 4'hF, 4'h0};
        int         ep [5] = '{8, 32, 480, 120, 24};
        int         eh [5] = '{5, 16, 240, 0, 0};
        for (int i = 0; i < 5; i++) begin
            set_cfg({1'b0, i[0]}, id[i], od[i], 5'h0, 2'h0, 1'b0, 1000);
            measure(0, 2, p, h);
            check("bypass period", 2 * ep[i], p);
            if (eh[i] != 0) check("bypass high", 2 * eh[i], h);
        end
        check("loop active", 0, pll);
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_half;
        set_cfg(2'h0, 2'h0, 4'h0, 5'h0, 2'h0, 1'b1, 100);
        measure(1, 4, p, h);
        check("cpu half period", 64, p);
        q = 0;
        repeat (64) begin
            @(negedge i_clk);
            if (sclk !== cclk) q++;
        end
        check("sys differs from cpu", 0, q);
        set_cfg(2'h0, 2'h0, 4'h0, 5'h0, 2'h0, 1'b0, 100);
        measure(1, 4, p, h);
        check("cpu full period", 32, p);
        $display("test halving done");
    endtask : t_half

    task automatic t_band;
        for (int b = 0; b < 3; b++) begin
            set_cfg(2'h0, 2'h0, 4'h0, 5'h0, b[1:0], 1'b0, 40);
            check("band", b, band);
            check("band error", 0, berr);
        end
        set_cfg(2'h0, 2'h0, 4'h0, 5'h0, 2'h3, 1'b0, 40);
        check("reserved band flag", 1, berr);
        check("band held", 2, band);
        $display("test band done");
    endtask : t_band

    task automatic t_pll;
        hi_ns <= 16'h0500;
        lo_ns <= 16'h0500;
        set_cfg(2'h3, 2'h0, 4'h0, 5'h1, 2'h0, 1'b0, 5000);
        check("loop active", 1, pll);
        measure(0, 8, p, h);
        check("loop period near 256", 1, p >= 240 && p <= 272);
        set_cfg(2'h3, 2'h0, 4'h1, 5'h1, 2'h0, 1'b0, 1000);
        measure(0, 4, p, h);
        check("loop odiv period near 256", 1, p >= 240 && p <= 272);
        set_cfg(2'h2, 2'h0, 4'h1, 5'h1, 2'h0, 1'b0, 300);
        check("mode kept", 1, pll);
        set_cfg(2'h3, 2'h0, 4'h0, 5'h3, 2'h0, 1'b0, 100);
        measure(0, 1, q, h);
        repeat (5) begin
            measure(0, 1, p, h);
            check("smooth step", 1, p - q <= 4 && q - p <= 4);
            q = p;
        end
        set_cfg(2'h0, 2'h0, 4'h0, 5'h0, 2'h0, 1'b0, 1000);
        check("loop off", 0, pll);
        $display("test loop done");
    endtask : t_pll

    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        check("reset outputs", 0, {mclk, cclk, sclk, pll, band, berr});
        t_band();
        t_bypass();
        t_half();
        t_pll();
        print_verdict();
    end
endmodule : tb_master_clock_generator

`default_nettype wire
